// file: scan_result_ram.sv
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------
// Single-port result buffer, registered read data
// -----------------------------------------------------------------
module scan_result_ram #(
  parameter int WIDTH  = 16,
  parameter int DEPTH  = 40,
  parameter int ADDR_W = 6
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              en,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [WIDTH-1:0]  wdata,
  output var  logic [WIDTH-1:0]  rdata_q
);

  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH > (1 << ADDR_W)) begin : g_depth_check
    $error("scan_result_ram: DEPTH does not fit ADDR_W");
  end

  wire in_range = (32'(addr) < DEPTH);

  always_ff @(posedge clk) begin
    if (en && we && in_range) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (en && !we) begin
      rdata_q <= in_range ? mem[addr] : '0;
    end
  end

endmodule

`default_nettype wire

// file: adc_scan_dma_capture.sv
// What this block does
// - Scan four inputs repeatedly once software starts
// - Each conversion updates result, pulses end request
// - One DMA transfer per conversion end request
// - DMA moves register data into RAM only
// - Source is always the fixed result register
// - 40-entry buffer from start address, sequential
// - DMA-end raised when 40 transfers used up
// - One run is ten rounds of four
// - DMA start clears end, enables, awaits trigger
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------
// Shared constants
// -----------------------------------------------------------------
package adc_dma_pkg;
  localparam int          DATA_W       = 16;
  localparam int          SAMPLE_W     = 10;
  localparam int          RESULT_SHIFT = 6;
  localparam int          CHANNELS     = 4;
  localparam int          ROUNDS       = 10;
  localparam int          TRANSFERS    = 40;
  localparam int          ENTRY_BYTES  = 2;
  localparam int          IDX_W        = 6;
  localparam int          DEST_W       = 8;
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          CONV_TIME_NS = 1000;
  localparam int          CONV_CYCLES  = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] CTRL_OFS     = 12'h000;
  localparam logic [11:0] STATUS_OFS   = 12'h004;
  localparam logic [11:0] DEST_OFS     = 12'h008;
  localparam logic [11:0] COUNT_OFS    = 12'h00C;
  localparam logic [11:0] RESULT_OFS   = 12'h010;
  localparam logic [11:0] LED_OFS      = 12'h014;
  localparam logic [11:0] RAM_BASE     = 12'h100;
  localparam logic [11:0] RAM_LAST     = 12'h19C;
  localparam int          CONV_BIT     = 0;
  localparam int          DMA_BIT      = 1;
  localparam int          IE_BIT       = 2;
  localparam int          END_BIT      = 2;
  localparam logic [DEST_W-1:0] DEST_RESET  = 8'h00;
  localparam logic [IDX_W-1:0]  COUNT_RESET = 6'h28;
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN  = 2'b01,
    CONV_HOLD = 2'b10
  } conv_state_type;
endpackage

module adc_scan_dma_capture #(
  parameter int CONV_CYCLES = adc_dma_pkg::CONV_CYCLES,
  parameter int TRANSFERS   = adc_dma_pkg::TRANSFERS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [9:0]  analog_input_0,
  input  wire logic [9:0]  analog_input_1,
  input  wire logic [9:0]  analog_input_2,
  input  wire logic [9:0]  analog_input_3,
  output var  logic        conversion_end_request,
  output var  logic        dma_end_request,
  output var  logic        led_output_0,
  output var  logic        led_output_1
);
  localparam int DW = adc_dma_pkg::DATA_W;
  localparam int IW = adc_dma_pkg::IDX_W;
  if (CONV_CYCLES < 1 || CONV_CYCLES > 255) begin : g_conv_check
    $error("adc_scan_dma_capture: CONV_CYCLES out of range");
  end
  if (TRANSFERS != adc_dma_pkg::CHANNELS * adc_dma_pkg::ROUNDS || TRANSFERS > 63) begin : g_xfer_check
    $error("adc_scan_dma_capture: TRANSFERS must equal channels times rounds");
  end
  function automatic logic [DW-1:0] left_justify(input logic [adc_dma_pkg::SAMPLE_W-1:0] s);
    left_justify = DW'({s, {adc_dma_pkg::RESULT_SHIFT{1'b0}}});
  endfunction
  function automatic logic [IW-1:0] ram_index(input logic [11:0] a);
    logic [11:0] off;
    off = a - adc_dma_pkg::RAM_BASE;
    ram_index = off[IW+1:2];
  endfunction
  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  adc_dma_pkg::conv_state_type state_q;
  logic [7:0]                    timer_q;
  logic [1:0]                    chan_q;
  logic [DW-1:0]                 result_q;
  logic                          conv_on_q;
  logic                          dma_en_q;
  logic                          end_ie_q;
  logic                          end_flag_q;
  logic [adc_dma_pkg::DEST_W-1:0] dest_q;
  logic [IW-1:0]                 count_q;
  logic [1:0]                    led_q;
  logic [DW-1:0]                 buf_data_q [2];
  logic [IW-1:0]                 buf_idx_q  [2];
  logic                          buf_wp_q;
  logic                          buf_rp_q;
  logic [1:0]                    buf_cnt_q;
  logic [DW-1:0]                 ram_rdata;
  // -----------------------------------------------------------------
  // APB decode
  // -----------------------------------------------------------------
  wire        setup      = psel && !penable;
  wire        access     = psel && penable && !pready;
  wire        done_xfer  = psel && penable && pready;
  wire        wr_done    = done_xfer && pwrite;
  wire        sel_ctrl   = (paddr == adc_dma_pkg::CTRL_OFS);
  wire        sel_status = (paddr == adc_dma_pkg::STATUS_OFS);
  wire        sel_dest   = (paddr == adc_dma_pkg::DEST_OFS);
  wire        sel_count  = (paddr == adc_dma_pkg::COUNT_OFS);
  wire        sel_result = (paddr == adc_dma_pkg::RESULT_OFS);
  wire        sel_led    = (paddr == adc_dma_pkg::LED_OFS);
  wire        sel_ram    = (paddr >= adc_dma_pkg::RAM_BASE) && (paddr <= adc_dma_pkg::RAM_LAST)
                           && (paddr[1:0] == 2'b00);
  wire        mapped     = sel_ctrl || sel_status || sel_dest || sel_count || sel_result
                           || sel_led || sel_ram;
  wire        ram_rd     = setup && !pwrite && sel_ram;
  wire        wr_ctrl    = wr_done && sel_ctrl;
  wire        dma_start  = wr_ctrl && pwdata[adc_dma_pkg::DMA_BIT];
  wire        end_w1c    = wr_done && sel_status && pwdata[adc_dma_pkg::END_BIT];
  // -----------------------------------------------------------------
  // Converter and DMA trigger
  // -----------------------------------------------------------------
  wire [9:0]    sample    = (chan_q == 2'd0) ? analog_input_0 :
                            (chan_q == 2'd1) ? analog_input_1 :
                            (chan_q == 2'd2) ? analog_input_2 : analog_input_3;
  wire          buf_full  = (buf_cnt_q == 2'd2);
  wire          blocked   = dma_en_q && buf_full;
  wire          conv_done = (state_q == adc_dma_pkg::CONV_HOLD) && conv_on_q && !blocked;
  wire          push      = conv_done && dma_en_q;
  wire          last_xfer = push && (count_q == IW'(1));
  wire [IW-1:0] push_idx  = dest_q[IW:1];
  wire          pop       = (buf_cnt_q != 2'd0) && !ram_rd;
  wire          end_flag_d = last_xfer || (end_flag_q && !end_w1c && !dma_start);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= adc_dma_pkg::CONV_IDLE;
      timer_q <= '0;
      chan_q  <= '0;
    end else begin
      case (state_q)
        adc_dma_pkg::CONV_IDLE: begin
          if (conv_on_q) begin
            state_q <= adc_dma_pkg::CONV_RUN;
            timer_q <= 8'(CONV_CYCLES - 1);
          end
        end
        adc_dma_pkg::CONV_RUN: begin
          if (!conv_on_q) begin
            state_q <= adc_dma_pkg::CONV_IDLE;
          end else if (timer_q == '0) begin
            state_q <= adc_dma_pkg::CONV_HOLD;
          end else begin
            timer_q <= timer_q - 8'h01;
          end
        end
        adc_dma_pkg::CONV_HOLD: begin
          if (!conv_on_q) begin
            state_q <= adc_dma_pkg::CONV_IDLE;
          end else if (conv_done) begin
            state_q <= adc_dma_pkg::CONV_RUN;
            timer_q <= 8'(CONV_CYCLES - 1);
            chan_q  <= chan_q + 2'd1;
          end
        end
        default: state_q <= adc_dma_pkg::CONV_IDLE;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q               <= '0;
      conversion_end_request <= 1'b0;
    end else begin
      conversion_end_request <= conv_done;
      if (conv_done) begin
        result_q <= left_justify(sample);
      end
    end
  end
  // -----------------------------------------------------------------
  // Control registers
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_on_q       <= 1'b0;
      dma_en_q        <= 1'b0;
      end_ie_q        <= 1'b0;
      end_flag_q      <= 1'b0;
      dest_q          <= adc_dma_pkg::DEST_RESET;
      count_q         <= adc_dma_pkg::COUNT_RESET;
      led_q           <= '0;
      dma_end_request <= 1'b0;
      led_output_0    <= 1'b0;
      led_output_1    <= 1'b0;
    end else begin
      end_flag_q      <= end_flag_d;
      dma_end_request <= end_flag_q && end_ie_q;
      if (wr_ctrl) begin
        conv_on_q <= pwdata[adc_dma_pkg::CONV_BIT];
        end_ie_q  <= pwdata[adc_dma_pkg::IE_BIT] || dma_start;
      end
      if (last_xfer) begin
        dma_en_q <= 1'b0;
      end else if (wr_ctrl) begin
        dma_en_q <= pwdata[adc_dma_pkg::DMA_BIT];
      end
      if (push) begin
        dest_q  <= dest_q + adc_dma_pkg::DEST_W'(adc_dma_pkg::ENTRY_BYTES);
        count_q <= count_q - IW'(1);
      end else begin
        if (wr_done && sel_dest) begin
          dest_q <= pwdata[adc_dma_pkg::DEST_W-1:0];
        end
        if (wr_done && sel_count) begin
          count_q <= pwdata[IW-1:0];
        end
      end
      if (wr_done && sel_led) begin
        led_q <= pwdata[1:0];
      end
      led_output_0 <= led_q[0];
      led_output_1 <= led_q[1];
    end
  end
  // -----------------------------------------------------------------
  // Two-entry transfer buffer
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_wp_q  <= 1'b0;
      buf_rp_q  <= 1'b0;
      buf_cnt_q <= '0;
    end else begin
      if (push) begin
        buf_wp_q <= !buf_wp_q;
      end
      if (pop) begin
        buf_rp_q <= !buf_rp_q;
      end
      buf_cnt_q <= buf_cnt_q + 2'(push) - 2'(pop);
    end
  end
  always_ff @(posedge pclk) begin
    if (push) begin
      buf_data_q[buf_wp_q] <= left_justify(sample);
      buf_idx_q[buf_wp_q]  <= push_idx;
    end
  end
  // -----------------------------------------------------------------
  // RAM port: bus reads win, buffer drains otherwise
  // -----------------------------------------------------------------
  wire [IW-1:0] ram_addr = ram_rd ? ram_index(paddr) : buf_idx_q[buf_rp_q];
  scan_result_ram #(
    .WIDTH  (DW),
    .DEPTH  (TRANSFERS),
    .ADDR_W (IW)
  ) u_ram (
    .clk     (pclk),
    .rst_n   (presetn),
    .en      (ram_rd || pop),
    .we      (pop),
    .addr    (ram_addr),
    .wdata   (buf_data_q[buf_rp_q]),
    .rdata_q (ram_rdata)
  );
  // -----------------------------------------------------------------
  // APB answer
  // -----------------------------------------------------------------
  wire [31:0] status_word = {22'h0, chan_q, 4'h0, end_ie_q, end_flag_q, dma_en_q, conv_on_q};
  wire [31:0] rd_mux = sel_ctrl   ? {29'h0, end_ie_q, dma_en_q, conv_on_q} :
                       sel_status ? status_word :
                       sel_dest   ? 32'(dest_q) :
                       sel_count  ? 32'(count_q) :
                       sel_result ? 32'(result_q) :
                       sel_led    ? 32'(led_q) :
                       sel_ram    ? 32'(ram_rdata) : 32'h0000_0000;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= access;
      pslverr <= access && !mapped;
      if (access && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end
  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_finish;
    (state_q == adc_dma_pkg::CONV_HOLD) && conv_on_q && !blocked;
  endsequence
  sequence s_reported;
    ##1 conversion_end_request && (result_q == $past(left_justify(sample)));
  endsequence
  AST_SCAN_ORDER: assert property (conv_done |=> chan_q == $past(chan_q) + 2'd1)
    else $error("scan did not advance to next channel");
  AST_RESULT_REQ: assert property (s_finish |-> s_reported)
    else $error("result or end request missing after conversion");
  AST_ONE_XFER: assert property (push |=> count_q == $past(count_q) - IW'(1))
    else $error("transfer count not decremented once");
  AST_DIRECTION: assert property (ram_rd |-> !pop)
    else $error("RAM written while bus reads it");
  AST_DEST_STEP: assert property (push |=> dest_q == $past(dest_q) + 8'h02)
    else $error("destination did not advance by two bytes");
  AST_DMA_END: assert property (last_xfer |=> end_flag_q && !dma_en_q ##1 dma_end_request || !end_ie_q)
    else $error("DMA end not raised after last transfer");
  AST_START: assert property (dma_start && !last_xfer |=> dma_en_q && end_ie_q && !end_flag_q)
    else $error("DMA start did not arm channel");
  AST_NO_LOSS: assert property (buf_full && dma_en_q |-> !push)
    else $error("word pushed into full buffer");
  AST_LED: assert property (wr_done && sel_led |=> ##1 led_output_0 == $past(pwdata[0], 2))
    else $error("LED output does not follow written value");
endmodule

`default_nettype wire

// file: analog_source.sv
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------
// Converter front end: four input levels, reloaded between runs
// -----------------------------------------------------------------
module analog_source (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       load,
  input  wire logic [9:0] next_0,
  input  wire logic [9:0] next_1,
  input  wire logic [9:0] next_2,
  input  wire logic [9:0] next_3,
  output var  logic [9:0] analog_input_0,
  output var  logic [9:0] analog_input_1,
  output var  logic [9:0] analog_input_2,
  output var  logic [9:0] analog_input_3
);
  // Levels stay steady through a run, so all rounds agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_input_0 <= 10'h000;
      analog_input_1 <= 10'h000;
      analog_input_2 <= 10'h000;
      analog_input_3 <= 10'h000;
    end else if (load) begin
      analog_input_0 <= next_0;
      analog_input_1 <= next_1;
      analog_input_2 <= next_2;
      analog_input_3 <= next_3;
    end
  end
endmodule

`default_nettype wire

// file: adc_scan_dma_capture_test.sv
`timescale 1ns/1ps
`default_nettype none

module adc_scan_dma_capture_test;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [9:0]  ain [4];
  logic [9:0]  nv [4];
  logic        load;
  logic        ce;
  logic        de;
  logic        l0;
  logic        l1;
  logic        err;
  logic [31:0] q;
  logic [31:0] seed;
  logic [15:0] exp_q [$];
  int          n_errors;
  int          num_checks;
  int          n_conv;
  bit          counting;

  // -----------------------------------------------------------------
  // Design, far side, clock
  // -----------------------------------------------------------------
  adc_scan_dma_capture #(.CONV_CYCLES(4), .TRANSFERS(40)) u_adc_scan_dma_capture (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analog_input_0(ain[0]), .analog_input_1(ain[1]), .analog_input_2(ain[2]),
    .analog_input_3(ain[3]), .conversion_end_request(ce), .dma_end_request(de),
    .led_output_0(l0), .led_output_1(l1));

  analog_source u_analog_source (
    .pclk(pclk), .presetn(presetn), .load(load), .next_0(nv[0]), .next_1(nv[1]),
    .next_2(nv[2]), .next_3(nv[3]), .analog_input_0(ain[0]), .analog_input_1(ain[1]),
    .analog_input_2(ain[2]), .analog_input_3(ain[3]));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (counting && ce === 1'b1) n_conv++;
  end

  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    q       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i >= 50) begin
      n_errors++;
      conclude();
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    t = t ^ (t << 5);
    return t;
  endfunction

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    int vals [4];
    int sums [4];
    int c0;
    int win;
    int got;
    int k;
    int cl;
    logic [11:0] bad [3];
    bad = '{12'h018, 12'h102, 12'h1A0};
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    load = 1'b0; nv = '{10'h000, 10'h000, 10'h000, 10'h000};
    seed = 32'h3; n_errors = 0; num_checks = 0; n_conv = 0; counting = 0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, adc_dma_pkg::DEST_OFS, 32'h0);
    chk("dest reset", q, 32'h0);
    apb(1'b0, adc_dma_pkg::COUNT_OFS, 32'h0);
    chk("count reset", q, 32'h28);
    apb(1'b0, adc_dma_pkg::STATUS_OFS, 32'h0);
    chk("status reset", q, 32'h0);
    foreach (bad[b]) begin
      apb(1'b0, bad[b], 32'h0);
      chk("unmapped err", 32'(err), 32'h1);
      chk("unmapped data", q, 32'h0);
    end
    $display("test reset_and_refusal done");
    for (int run = 0; run < 3; run++) begin
      for (k = 0; k < 4; k++) begin
        seed = xs(seed);
        vals[k] = (run == 1) ? ((k % 2 == 1) ? 700 : 300) : int'(seed[9:0]);
        nv[k] <= 10'(vals[k]);
      end
      load <= 1'b1;
      @(posedge pclk);
      load <= 1'b0;
      apb(1'b0, adc_dma_pkg::STATUS_OFS, 32'h0);
      c0 = int'(q[9:8]);
      apb(1'b1, adc_dma_pkg::DEST_OFS, 32'h0);
      apb(1'b1, adc_dma_pkg::COUNT_OFS, 32'h28);
      n_conv = 0;
      counting = 1;
      apb(1'b1, adc_dma_pkg::CTRL_OFS, 32'h3);
      repeat (2) @(posedge pclk);
      chk("dma end after start", 32'(de), 32'h0);
      k = 0;
      while (de !== 1'b1 && k < 3000) begin
        @(posedge pclk);
        k++;
      end
      counting = 0;
      if (k >= 3000) begin
        n_errors++;
        conclude();
      end
      chk("conversions per run", 32'(n_conv), 32'h28);
      apb(1'b1, adc_dma_pkg::CTRL_OFS, 32'h0);
      apb(1'b0, adc_dma_pkg::STATUS_OFS, 32'h0);
      chk("status after run", {29'h0, q[2:0]}, 32'h4);
      cl = (int'(q[9:8]) + 3) % 4;
      apb(1'b0, adc_dma_pkg::RESULT_OFS, 32'h0);
      chk("result reg", q, 32'(vals[cl]) << 6);
      apb(1'b1, adc_dma_pkg::STATUS_OFS, 32'h4);
      apb(1'b0, adc_dma_pkg::STATUS_OFS, 32'h0);
      chk("end flag cleared", 32'(q[2]), 32'h0);
      apb(1'b0, adc_dma_pkg::COUNT_OFS, 32'h0);
      chk("count after run", q, 32'h0);
      apb(1'b0, adc_dma_pkg::DEST_OFS, 32'h0);
      chk("dest after run", q, 32'h50);
      for (k = 0; k < 40; k++) exp_q.push_back({6'(0) + 10'(vals[(c0 + k) % 4]), 6'h00});
      sums = '{0, 0, 0, 0};
      for (k = 0; k < 40; k++) begin
        apb(1'b0, adc_dma_pkg::RAM_BASE + 12'(4 * k), 32'h0);
        chk("ram entry", q, {16'h0, exp_q.pop_front()});
        sums[(c0 + k) % 4] += int'(q[15:6]);
      end
      win = 0;
      got = 0;
      for (k = 1; k < 4; k++) begin
        if (vals[k] > vals[win]) win = k;
        if (sums[k] > sums[got]) got = k;
      end
      chk("winner", 32'(got), 32'(win));
      apb(1'b1, adc_dma_pkg::LED_OFS, 32'(got));
      repeat (2) @(posedge pclk);
      chk("leds", {30'h0, l1, l0}, 32'(win));
      $display("test capture_run %0d done", run);
    end
    conclude();
  end
endmodule

`default_nettype wire
